// ### fbcd_bus_if.sv
// Carrier between the sequencer and the single bus-cycle engine.
interface fbcd_bus_if;
  import fbcd_pkg::*;
  logic start;
  fbcd_cyc_t cyc;
  logic done;
  logic [15:0] rdData;
  modport seq (output start, output cyc, input done, input rdData);
  modport eng (input start, input cyc, output done, output rdData);
endinterface

// ### fbcd_consts.svh
// Timing counts, command codes and query offsets for the flash bank command host.
`ifndef FBCD_CONSTS_SVH
`define FBCD_CONSTS_SVH
`define FBCD_CLK_NS 50
`define FBCD_T_STROBE_NS 100
`define FBCD_T_STROBE_CYC ((`FBCD_T_STROBE_NS + `FBCD_CLK_NS - 1) / `FBCD_CLK_NS)
`define FBCD_T_ACC_NS 110
`define FBCD_T_ACC_CYC ((`FBCD_T_ACC_NS + `FBCD_CLK_NS - 1) / `FBCD_CLK_NS)
`define FBCD_UNLOCK_ADDR1 22'h00_0555
`define FBCD_UNLOCK_DATA1 16'h00AA
`define FBCD_UNLOCK_ADDR2 22'h00_02AA
`define FBCD_UNLOCK_DATA2 16'h0055
`define FBCD_CMD_AUTOSEL 16'h0090
`define FBCD_CMD_RESET 16'h00F0
`define FBCD_CMD_SEC_ENTER 16'h0088
`define FBCD_CMD_SEC_EXIT 16'h0090
`define FBCD_CMD_SEC_EXIT2 16'h0000
`define FBCD_AS_MAKER_W 22'h00_0000
`define FBCD_AS_PART_W 22'h00_0001
`define FBCD_AS_PART_B 22'h00_0002
`define FBCD_AS_PROT_W 22'h00_0002
`define FBCD_AS_PROT_B 22'h00_0004
`define FBCD_AS_FACT_W 22'h00_0003
`define FBCD_AS_FACT_B 22'h00_0006
`define FBCD_FACT_LOCKED 8'h85
`define FBCD_FACT_OPEN 8'h05
`define FBCD_QRY_BASE_W 22'h00_0040
`define FBCD_QRY_BASE_B 22'h00_0080
`define FBCD_QRY_BOOT_W 22'h00_004F
`define FBCD_BOOT_BOTTOM 8'h02
`define FBCD_BOOT_TOP 8'h03
`endif

// ### fbcd_cycle.sv
// One asynchronous flash bus cycle: chip select and write strobe timed by cycle counts.
`include "fbcd_consts.svh"
module fbcd_cycle
  import fbcd_pkg::*;
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic resetn,
  // Sequencer side.
  fbcd_bus_if.eng bus,
  // Flash pins.
  output logic [21:0] flashAddr,
  output logic [15:0] flashDataOut,
  output logic flashDataOe,
  input wire logic [15:0] flashDataIn,
  output logic chipSelN,
  output logic writeStrobeN,
  output logic readStrobeN
);
  localparam int STROBE = `FBCD_T_STROBE_CYC;
  localparam int ACC = `FBCD_T_ACC_CYC + 2;
  logic [15:0] dSync1;
  logic [15:0] dSync2;
  logic [3:0] cnt;
  logic busy;
  logic isWr;
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      dSync1 <= 16'h0000;
      dSync2 <= 16'h0000;
    end
    else
    begin
      dSync1 <= flashDataIn;
      dSync2 <= dSync1;
    end
  end
  // Both strobes fall together so the address is valid before the later edge,
  // and the write strobe rises before chip select so data is taken on it. R2 R3
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      busy <= 1'b0;
      isWr <= 1'b0;
      cnt <= 4'h0;
      chipSelN <= 1'b1;
      writeStrobeN <= 1'b1;
      readStrobeN <= 1'b1;
      flashAddr <= 22'h00_0000;
      flashDataOut <= 16'h0000;
      flashDataOe <= 1'b0;
      bus.done <= 1'b0;
      bus.rdData <= 16'h0000;
    end
    else
    begin
      bus.done <= 1'b0;
      if (!busy && bus.start)
      begin
        busy <= 1'b1;
        isWr <= bus.cyc.wr;
        cnt <= 4'h0;
        flashAddr <= bus.cyc.addr;
        flashDataOut <= bus.cyc.data;
        flashDataOe <= bus.cyc.wr;
        chipSelN <= 1'b0;
        writeStrobeN <= !bus.cyc.wr;
        readStrobeN <= bus.cyc.wr;
      end
      else if (busy)
      begin
        cnt <= cnt + 4'h1;
        if (isWr && cnt == 4'(STROBE - 1))
          writeStrobeN <= 1'b1;
        if (isWr && cnt == 4'(STROBE))
        begin
          chipSelN <= 1'b1;
          flashDataOe <= 1'b0;
          busy <= 1'b0;
          bus.done <= 1'b1;
        end
        if (!isWr && cnt == 4'(ACC))
        begin
          bus.rdData <= dSync2;
          chipSelN <= 1'b1;
          readStrobeN <= 1'b1;
          busy <= 1'b0;
          bus.done <= 1'b1;
        end
      end
    end
  end
  writeFirst_a: assert property (@(posedge core_clk) disable iff (!resetn)
    $rose(writeStrobeN) && isWr |-> !chipSelN ##1 chipSelN) else $error("write strobe not first"); // R3
  addrHeld_a: assert property (@(posedge core_clk) disable iff (!resetn)
    !chipSelN && $past(!chipSelN) |-> $stable(flashAddr)) else $error("address moved in cycle"); // R2
endmodule

// ### fbcd_flash_model.sv
// Behavioural model of the flash device as seen from its pins.
`include "fbcd_consts.svh"
module fbcd_flash_model
(
  // Flash pins.
  input wire logic [21:0] flashAddr,
  input wire logic [15:0] flashDataOut,
  input wire logic flashDataOe,
  output logic [15:0] flashDataIn,
  input wire logic chipSelN,
  input wire logic writeStrobeN,
  input wire logic readStrobeN,
  input wire logic flashResetN,
  // Width select pin.
  input wire logic byteMode
);
  timeunit 1ns;
  timeprecision 1ns;
  // Identification codes are arbitrary.
  localparam logic [15:0] MAKER_CODE = 16'h00C3;
  localparam logic [15:0] PART_CODE = 16'h4A11;
  logic [21:0] latAddr = 22'h00_0000;
  logic [1:0] step = 2'h0;
  logic autoMode = 1'b0;
  logic secMode = 1'b0;
  logic [2:0] idx;
  logic [15:0] asVal;
  logic [7:0] qOff;

  always @(negedge writeStrobeN or negedge chipSelN)
    if (!writeStrobeN && !chipSelN) latAddr = flashAddr;

  task automatic take(input logic [15:0] d);
    if (d == `FBCD_CMD_RESET)
    begin
      step = 2'h0;
      autoMode = 1'b0;
    end
    else if (step == 2'h0 && latAddr == `FBCD_UNLOCK_ADDR1 && d == `FBCD_UNLOCK_DATA1) step = 2'h1;
    else if (step == 2'h1 && latAddr == `FBCD_UNLOCK_ADDR2 && d == `FBCD_UNLOCK_DATA2) step = 2'h2;
    else if (step == 2'h2 && secMode && d == `FBCD_CMD_SEC_EXIT) step = 2'h3;
    else if (step == 2'h2 && d == `FBCD_CMD_AUTOSEL)
    begin
      autoMode = 1'b1;
      step = 2'h0;
    end
    else if (step == 2'h2 && d == `FBCD_CMD_SEC_ENTER)
    begin
      secMode = 1'b1;
      step = 2'h0;
    end
    else if (step == 2'h3 && d == `FBCD_CMD_SEC_EXIT2)
    begin
      secMode = 1'b0;
      step = 2'h0;
    end
    else step = 2'h0;
  endtask

  always @(posedge writeStrobeN)
    if (!chipSelN) take(flashDataOut);
  always @(posedge chipSelN)
    if (!writeStrobeN) take(flashDataOut);
  always @(negedge flashResetN)
  begin
    step = 2'h0;
    autoMode = 1'b0;
    secMode = 1'b0;
  end

  // Vendor query words are answered beside the identification words.
  function automatic logic [15:0] queryWord(input logic [7:0] off);
    case (off)
      8'h40: queryWord = 16'h0050;
      8'h41: queryWord = 16'h0052;
      8'h42: queryWord = 16'h0049;
      8'h43: queryWord = 16'h0031;
      8'h44: queryWord = 16'h0032;
      default: queryWord = {8'h00, `FBCD_BOOT_BOTTOM};
    endcase
  endfunction

  initial flashDataIn = 16'h0000;
  // A released bus shows the inverse of its last value, never a stale match.
  always @(flashAddr or chipSelN or readStrobeN or flashDataOe or autoMode or secMode or byteMode)
  begin
    idx = byteMode ? flashAddr[3:1] : flashAddr[2:0];
    case (idx)
      3'h0: asVal = MAKER_CODE;
      3'h1: asVal = PART_CODE;
      3'h2: asVal = {15'h0000, flashAddr[12]};
      3'h3: asVal = {8'h00, `FBCD_FACT_LOCKED};
      default: asVal = 16'hFFFF;
    endcase
    qOff = byteMode ? flashAddr[8:1] : flashAddr[7:0];
    if (qOff[7:4] == 4'h4 && (qOff[3:0] <= 4'h4 || qOff[3:0] == 4'hF)) asVal = queryWord(qOff);
    if (chipSelN || readStrobeN || flashDataOe) flashDataIn = ~flashDataIn;
    else if (autoMode) flashDataIn = byteMode ? {8'hA5, asVal[7:0]} : asVal;
    else if (secMode) flashDataIn = {4'hE, flashAddr[11:0]};
    else flashDataIn = flashAddr[15:0] ^ 16'h3C3C;
  end
endmodule

// ### fbcd_host.sv
// Host controller that issues flash command sequences and reads through the bus-cycle engine.
// Contract
// R1: Unexpected writes make the flash drop the partial command; host re-issues from scratch.
// R2: Flash latches address on later falling edge of write strobe or chip select.
// R3: Flash latches data on earlier rising edge of write strobe or chip select.
// R4: After power-up banks are in read-array; host reads without commands.
// R5: A bank returns to read-array by itself after program or erase.
// R6: Erase-suspend gives erase-suspend-read mode, also after suspended program ends.
// R7: Reset command ignores address and restores read or erase-suspend-read mode.
// R8: Reset mid erase sequence aborts it; during erasure reset is ignored.
// R9: Reset mid program sequence aborts it; during programming reset is ignored.
// R10: Reset during or in autoselect returns to read or erase-suspend-read.
// R11: When timing-limit flag rises the host issues reset; here the host only raises timingLimit and the user sends reset.
// R12: Host issues autoselect only to an idle bank while other bank is not busy.
// R13: Autoselect entry is two unlock writes then bank address with command.
// R14: In autoselect any number of reads within the bank need no re-entry.
// R15: Maker code at bank+00; part code at bank+01 word or +02 byte.
// R16: Sector lock at sector+02 word or +04 byte: 00 open, 01 locked.
// R17: Factory lock at bank+03 word or +06 byte: 85 locked, 05 not.
// R18: In byte mode host ignores upper data bits of autoselect reads.
// R19: Three-cycle entry redirects to secured region until four-cycle exit.
// R20: Hardware reset pin low returns device to read-array, leaving secured region.
// R21: Vendor query region starts at 40h word or 80h byte with tag.
// R22: Query word 4Fh gives boot location: 02h bottom, 03h top.
// R23: Unlock addresses, data and command codes are parameters; the second exit code is taken from FBCD_CMD_SEC_EXIT2 directly.
`include "fbcd_consts.svh"
module fbcd_host
  import fbcd_pkg::*;
#(
  parameter logic [21:0] UNLOCK_ADDR1 = `FBCD_UNLOCK_ADDR1, // R23
  parameter logic [15:0] UNLOCK_DATA1 = `FBCD_UNLOCK_DATA1,
  parameter logic [21:0] UNLOCK_ADDR2 = `FBCD_UNLOCK_ADDR2,
  parameter logic [15:0] UNLOCK_DATA2 = `FBCD_UNLOCK_DATA2,
  parameter logic [15:0] CMD_AUTOSEL = `FBCD_CMD_AUTOSEL,
  parameter logic [15:0] CMD_RESET = `FBCD_CMD_RESET,
  parameter logic [15:0] CMD_SEC_ENTER = `FBCD_CMD_SEC_ENTER,
  parameter logic [15:0] CMD_SEC_EXIT = `FBCD_CMD_SEC_EXIT
)
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic resetn,
  // Command port.
  input wire logic reqValid,
  input wire fbcd_op_t reqOp,
  input wire logic [21:0] reqAddr,
  input wire logic [15:0] reqData,
  input wire logic byteMode,
  output logic reqReady,
  output logic rspValid,
  output logic [15:0] rspData,
  output logic inAutosel,
  output logic inSecured,
  output logic timingLimit,
  // Flash pins.
  output logic [21:0] flashAddr,
  output logic [15:0] flashDataOut,
  output logic flashDataOe,
  input wire logic [15:0] flashDataIn,
  output logic chipSelN,
  output logic writeStrobeN,
  output logic readStrobeN,
  output logic flashResetN
);
  typedef enum logic [2:0] {S_IDLE, S_PINRST, S_ISSUE, S_WAIT, S_DONE} fbcd_state_t;
  fbcd_bus_if bus();
  fbcd_state_t state;
  fbcd_op_t op;
  logic [21:0] addr;
  logic [15:0] data;
  logic [2:0] step;
  logic [2:0] lastStep;
  logic [3:0] rstCnt;
  logic isByte;

  function automatic fbcd_cyc_t seqCycle(input fbcd_op_t o, input logic [2:0] s,
                                         input logic [21:0] a, input logic [15:0] d);
    seqCycle = '{addr: a, data: d, wr: 1'b1};
    unique case (o)
      FBCD_OP_READ: seqCycle = '{addr: a, data: 16'h0000, wr: 1'b0};
      FBCD_OP_RESET: seqCycle = '{addr: 22'h00_0000, data: CMD_RESET, wr: 1'b1}; // R7
      FBCD_OP_WRITE: seqCycle = '{addr: a, data: d, wr: 1'b1};
      FBCD_OP_AUTOSEL, FBCD_OP_SEC_ENTER, FBCD_OP_SEC_EXIT:
      begin
        // Two unlock writes open each autoselect and secured-region sequence; reset has none. R13 R19
        if (s == 3'd0)
          seqCycle = '{addr: UNLOCK_ADDR1, data: UNLOCK_DATA1, wr: 1'b1};
        else if (s == 3'd1)
          seqCycle = '{addr: UNLOCK_ADDR2, data: UNLOCK_DATA2, wr: 1'b1};
        else if (o == FBCD_OP_AUTOSEL)
          seqCycle = '{addr: a, data: CMD_AUTOSEL, wr: 1'b1}; // R13
        else if (o == FBCD_OP_SEC_ENTER)
          seqCycle = '{addr: UNLOCK_ADDR1, data: CMD_SEC_ENTER, wr: 1'b1}; // R19
        else if (s == 3'd2)
          seqCycle = '{addr: UNLOCK_ADDR1, data: CMD_SEC_EXIT, wr: 1'b1};
        else
          seqCycle = '{addr: a, data: `FBCD_CMD_SEC_EXIT2, wr: 1'b1}; // R19
      end
      default: seqCycle = '{addr: a, data: d, wr: 1'b1};
    endcase
  endfunction

  function automatic logic [2:0] seqLen(input fbcd_op_t o);
    unique case (o)
      FBCD_OP_AUTOSEL, FBCD_OP_SEC_ENTER: seqLen = 3'd2;
      FBCD_OP_SEC_EXIT: seqLen = 3'd3;
      default: seqLen = 3'd0;
    endcase
  endfunction

  fbcd_cycle engine (
    .core_clk(core_clk),
    .resetn(resetn),
    .bus(bus.eng),
    .flashAddr(flashAddr),
    .flashDataOut(flashDataOut),
    .flashDataOe(flashDataOe),
    .flashDataIn(flashDataIn),
    .chipSelN(chipSelN),
    .writeStrobeN(writeStrobeN),
    .readStrobeN(readStrobeN)
  );

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state <= S_PINRST;
      op <= FBCD_OP_READ;
      addr <= 22'h00_0000;
      data <= 16'h0000;
      step <= 3'd0;
      lastStep <= 3'd0;
      rstCnt <= 4'h0;
      isByte <= 1'b0;
      reqReady <= 1'b0;
      rspValid <= 1'b0;
      rspData <= 16'h0000;
      flashResetN <= 1'b0;
      bus.start <= 1'b0;
      bus.cyc <= '0;
    end
    else
    begin
      rspValid <= 1'b0;
      bus.start <= 1'b0;
      unique case (state)
        S_PINRST:
        begin
          // Pulse the hardware reset pin so the flash starts in read-array. R20 R4
          rstCnt <= rstCnt + 4'h1;
          if (rstCnt == 4'(`FBCD_T_STROBE_CYC + 1))
          begin
            flashResetN <= 1'b1;
            reqReady <= 1'b1;
            state <= S_IDLE;
          end
        end
        S_IDLE:
        begin
          if (reqValid)
          begin
            // A fresh request always restarts its sequence from step 0, the first unlock for autoselect and secured-region commands. R1
            // Sequences start only from idle and the host never programs or erases. R12
            reqReady <= 1'b0;
            op <= reqOp;
            addr <= reqAddr;
            data <= reqData;
            isByte <= byteMode;
            step <= 3'd0;
            lastStep <= seqLen(reqOp);
            state <= S_ISSUE;
          end
        end
        S_ISSUE:
        begin
          bus.start <= 1'b1;
          bus.cyc <= seqCycle(op, step, addr, data);
          state <= S_WAIT;
        end
        S_WAIT:
        begin
          if (bus.done)
          begin
            if (step == lastStep)
              state <= S_DONE;
            else
            begin
              step <= step + 3'd1;
              state <= S_ISSUE;
            end
          end
        end
        S_DONE:
        begin
          rspValid <= 1'b1;
          // Only reads carry data, so a stale read word never poses as a command answer.
          // Upper bits are dropped for byte-wide reads in autoselect. R18
          if (op != FBCD_OP_READ)
            rspData <= 16'h0000;
          else if (isByte && inAutosel)
            rspData <= {8'h00, bus.rdData[7:0]}; // R18
          else
            rspData <= bus.rdData;
          reqReady <= 1'b1;
          state <= S_IDLE;
        end
        default: state <= S_PINRST;
      endcase
    end
  end

  // Mode tracking mirrors the flash's state after each finished autoselect, reset or secured-region sequence; plain writes are not tracked.
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      inAutosel <= 1'b0;
      inSecured <= 1'b0;
    end
    else if (state == S_DONE)
    begin
      if (op == FBCD_OP_AUTOSEL)
        inAutosel <= 1'b1; // R13 R14
      if (op == FBCD_OP_RESET)
        inAutosel <= 1'b0; // R10
      if (op == FBCD_OP_SEC_ENTER)
        inSecured <= 1'b1; // R19
      if (op == FBCD_OP_SEC_EXIT)
        inSecured <= 1'b0; // R19
    end
  end

  // Bit 5 of any read word raises timingLimit; the user must then send reset. R11
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      timingLimit <= 1'b0;
    else if (state == S_DONE && op == FBCD_OP_READ && bus.rdData[5])
      timingLimit <= 1'b1; // R11
    else if (state == S_DONE && op == FBCD_OP_RESET)
      timingLimit <= 1'b0;
  end

  resetCmd_a: assert property (@(posedge core_clk) disable iff (!resetn)
    bus.start && op == FBCD_OP_RESET |-> bus.cyc.data == CMD_RESET && bus.cyc.wr) else $error("bad reset cycle"); // R7
  unlockFirst_a: assert property (@(posedge core_clk) disable iff (!resetn)
    bus.start && op == FBCD_OP_AUTOSEL && step == 3'd0 |-> bus.cyc.addr == UNLOCK_ADDR1
    && bus.cyc.data == UNLOCK_DATA1) else $error("first unlock wrong"); // R13
  autoselCmd_a: assert property (@(posedge core_clk) disable iff (!resetn)
    bus.start && op == FBCD_OP_AUTOSEL && step == 3'd2 |-> bus.cyc.data == CMD_AUTOSEL
    && bus.cyc.addr == addr) else $error("autoselect write wrong"); // R13
  autoselSet_a: assert property (@(posedge core_clk) disable iff (!resetn)
    state == S_DONE && op == FBCD_OP_AUTOSEL |=> inAutosel) else $error("autoselect not tracked"); // R14
  autoselClear_a: assert property (@(posedge core_clk) disable iff (!resetn)
    state == S_DONE && op == FBCD_OP_RESET |=> !inAutosel) else $error("reset did not leave autoselect"); // R10
  secEnter_a: assert property (@(posedge core_clk) disable iff (!resetn)
    state == S_DONE && op == FBCD_OP_SEC_ENTER |=> inSecured) else $error("secured entry lost"); // R19
  secExit_a: assert property (@(posedge core_clk) disable iff (!resetn)
    state == S_DONE && op == FBCD_OP_SEC_EXIT |=> !inSecured) else $error("secured exit lost"); // R19
  pinReset_a: assert property (@(posedge core_clk) disable iff (!resetn)
    !flashResetN |-> !reqReady && !inSecured) else $error("ready during pin reset"); // R20
  byteMask_a: assert property (@(posedge core_clk) disable iff (!resetn)
    rspValid && isByte && inAutosel |-> rspData[15:8] == 8'h00) else $error("upper bits kept"); // R18
  limitClear_a: assert property (@(posedge core_clk) disable iff (!resetn)
    state == S_DONE && op == FBCD_OP_RESET |=> !timingLimit) else $error("limit not cleared"); // R11
  autoselSeq_c: cover property (@(posedge core_clk) state == S_DONE && op == FBCD_OP_AUTOSEL);
  secExit_c: cover property (@(posedge core_clk) state == S_DONE && op == FBCD_OP_SEC_EXIT);
  readDone_c: cover property (@(posedge core_clk) rspValid && op == FBCD_OP_READ);
endmodule

// ### fbcd_host_tb.sv
// Self-checking testbench of the flash bank command host.
`include "fbcd_consts.svh"
module fbcd_host_tb
  import fbcd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [21:0] BANK = 22'h10_0000;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic reqValid = 1'b0;
  fbcd_op_t reqOp = FBCD_OP_READ;
  logic [21:0] reqAddr = 22'h00_0000;
  logic [15:0] reqData = 16'h0000;
  logic byteMode = 1'b0;
  logic reqReady, rspValid, inAutosel, inSecured, timingLimit;
  logic [15:0] rspData, flashDataOut, flashDataIn;
  logic [21:0] flashAddr;
  logic flashDataOe, chipSelN, writeStrobeN, readStrobeN, flashResetN;
  int fails = 0;
  int cmp_count = 0;

  always #25 core_clk = ~core_clk;

  fbcd_host i_dut (.core_clk(core_clk), .resetn(resetn), .reqValid(reqValid), .reqOp(reqOp),
    .reqAddr(reqAddr), .reqData(reqData), .byteMode(byteMode), .reqReady(reqReady),
    .rspValid(rspValid), .rspData(rspData), .inAutosel(inAutosel), .inSecured(inSecured),
    .timingLimit(timingLimit), .flashAddr(flashAddr), .flashDataOut(flashDataOut),
    .flashDataOe(flashDataOe), .flashDataIn(flashDataIn), .chipSelN(chipSelN),
    .writeStrobeN(writeStrobeN), .readStrobeN(readStrobeN), .flashResetN(flashResetN));

  fbcd_flash_model i_flash (.flashAddr(flashAddr), .flashDataOut(flashDataOut),
    .flashDataOe(flashDataOe), .flashDataIn(flashDataIn), .chipSelN(chipSelN),
    .writeStrobeN(writeStrobeN), .readStrobeN(readStrobeN), .flashResetN(flashResetN),
    .byteMode(byteMode));

  task automatic end_sim();
    $display("Comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Called at a falling edge; returns at the falling edge where rspValid stands.
  task automatic do_op(input fbcd_op_t op, input logic [21:0] a, input logic [15:0] d);
    int n;
    n = 0;
    while (reqReady !== 1'b1 && n < 100)
    begin
      @(negedge core_clk);
      n++;
    end
    if (n >= 100) check("ready", 16'h0001, 16'h0000);
    reqValid = 1'b1;
    reqOp = op;
    reqAddr = a;
    reqData = d;
    @(negedge core_clk);
    reqValid = 1'b0;
    n = 0;
    while (rspValid !== 1'b1 && n < 200)
    begin
      @(negedge core_clk);
      n++;
    end
    if (n >= 200) check("response", 16'h0001, 16'h0000);
  endtask

  task automatic rd(input logic [21:0] a, input string name, input logic [15:0] exp);
    do_op(FBCD_OP_READ, a, 16'h0000);
    check(name, exp, rspData);
  endtask

  function automatic logic [15:0] arr(input logic [21:0] a);
    return a[15:0] ^ 16'h3C3C;
  endfunction

  task automatic t_autosel_word();
    do_op(FBCD_OP_AUTOSEL, BANK, 16'h0000);
    check("inAutosel", 16'h0001, {15'h0000, inAutosel});
    rd(BANK, "maker", 16'h00C3);
    rd(BANK + 22'h00_0001, "part", 16'h4A11);
    rd(BANK + 22'h00_0003, "factory", 16'h0085);
    rd(BANK + 22'h00_1002, "locked", 16'h0001);
    rd(BANK + 22'h00_0002, "open", 16'h0000);
    rd(BANK, "maker again", 16'h00C3);
    rd(BANK + `FBCD_QRY_BASE_W, "query tag P", 16'h0050);
    rd(BANK + 22'h00_0042, "query tag I", 16'h0049);
    rd(BANK + 22'h00_0043, "query major", 16'h0031);
    rd(BANK + `FBCD_QRY_BOOT_W, "boot flag", {8'h00, `FBCD_BOOT_BOTTOM});
    do_op(FBCD_OP_RESET, 22'h3F_FFFF, 16'h0000);
    check("inAutosel", 16'h0000, {15'h0000, inAutosel});
    rd(22'h00_0123, "array", arr(22'h00_0123));
  endtask

  task automatic t_autosel_byte();
    byteMode = 1'b1;
    do_op(FBCD_OP_AUTOSEL, BANK, 16'h0000);
    rd(BANK, "maker byte", 16'h00C3);
    rd(BANK + 22'h00_0002, "part byte", 16'h0011);
    rd(BANK + 22'h00_1004, "locked byte", 16'h0001);
    rd(BANK + 22'h00_0006, "factory byte", 16'h0085);
    rd(BANK + `FBCD_QRY_BASE_B, "query tag byte", 16'h0050);
    rd(BANK + 22'h00_0082, "query R byte", 16'h0052);
    do_op(FBCD_OP_RESET, BANK, 16'h0000);
    byteMode = 1'b0;
  endtask

  task automatic t_abort();
    do_op(FBCD_OP_WRITE, `FBCD_UNLOCK_ADDR1, `FBCD_UNLOCK_DATA1);
    do_op(FBCD_OP_WRITE, `FBCD_UNLOCK_ADDR2, 16'h0056);
    do_op(FBCD_OP_WRITE, BANK, `FBCD_CMD_AUTOSEL);
    rd(22'h00_0123, "after bad data", arr(22'h00_0123));
    do_op(FBCD_OP_WRITE, `FBCD_UNLOCK_ADDR1, `FBCD_UNLOCK_DATA1);
    do_op(FBCD_OP_WRITE, 22'h00_0777, `FBCD_CMD_RESET);
    do_op(FBCD_OP_WRITE, `FBCD_UNLOCK_ADDR2, `FBCD_UNLOCK_DATA2);
    do_op(FBCD_OP_WRITE, BANK, `FBCD_CMD_AUTOSEL);
    rd(22'h00_0123, "after mid reset", arr(22'h00_0123));
  endtask

  task automatic t_secured();
    do_op(FBCD_OP_SEC_ENTER, 22'h00_0000, 16'h0000);
    check("inSecured", 16'h0001, {15'h0000, inSecured});
    rd(22'h00_0123, "secured", 16'hE123);
    do_op(FBCD_OP_SEC_EXIT, 22'h00_0000, 16'h0000);
    check("inSecured", 16'h0000, {15'h0000, inSecured});
    rd(22'h00_0123, "after exit", arr(22'h00_0123));
    do_op(FBCD_OP_SEC_ENTER, 22'h00_0000, 16'h0000);
    resetn = 1'b0;
    repeat (2) @(negedge core_clk);
    check("flashResetN", 16'h0000, {15'h0000, flashResetN});
    resetn = 1'b1;
    check("inSecured", 16'h0000, {15'h0000, inSecured});
    rd(22'h00_0123, "after pin reset", arr(22'h00_0123));
  endtask

  task automatic t_timing();
    rd(22'h00_0011, "limit read", arr(22'h00_0011));
    check("timingLimit", 16'h0001, {15'h0000, timingLimit});
    do_op(FBCD_OP_RESET, 22'h00_0000, 16'h0000);
    check("timingLimit", 16'h0000, {15'h0000, timingLimit});
  endtask

  initial
  begin
    repeat (6) @(negedge core_clk);
    resetn = 1'b1;
    rd(22'h00_0123, "power-up array", arr(22'h00_0123));
    t_autosel_word();
    t_autosel_byte();
    t_abort();
    t_secured();
    t_timing();
    end_sim();
  end

  initial
  begin
    #1_000_000;
    fails++;
    $display("ERROR watchdog expected completion seen hang");
    end_sim();
  end
endmodule

// ### fbcd_pkg.sv
// Types shared by the flash bank command host.
package fbcd_pkg;
  typedef enum logic [2:0] {
    FBCD_OP_READ,
    FBCD_OP_RESET,
    FBCD_OP_AUTOSEL,
    FBCD_OP_SEC_ENTER,
    FBCD_OP_SEC_EXIT,
    FBCD_OP_WRITE
  } fbcd_op_t;
  typedef struct packed {
    logic [21:0] addr;
    logic [15:0] data;
    logic wr;
  } fbcd_cyc_t;
endpackage
